/* File: common/cpu_regs_pkg.sv */
// Constants, field positions and codes for the CPU register model.
// Assumes one clock domain; shared by the top and the register bank.
package cpu_regs_pkg;
   localparam int GPR_COUNT = 8;
   localparam int GPR_SEL_W = 3;
   localparam logic [2:0] SP_INDEX = 3'h7;

   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;
   localparam int FLAG_U4 = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_U6 = 6;
   localparam int FLAG_I = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h80;

   localparam int BYTE_MSB = 7;
   localparam int WORD_MSB = 15;
   localparam int BITNUM_LSB = 4;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] EVEN_MASK = 16'hFFFE;
   localparam logic [7:0] PAGE_HIGH = 8'hFF;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [7:0] BCD_LO_FIX = 8'h06;
   localparam logic [7:0] BCD_HI_FIX = 8'h60;
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
   localparam logic [1:0] BE_WORD = 2'h3;
   localparam logic [1:0] BE_HIGH = 2'h2;
   localparam logic [1:0] BE_LOW = 2'h1;

   typedef enum logic [1:0] {
      HALF_WORD = 2'h0, HALF_HIGH = 2'h1, HALF_LOW = 2'h2
   } half_sel_type;

   typedef enum logic [3:0] {
      EA_REG_IND = 4'h0, EA_DISP16 = 4'h1, EA_POSTINC = 4'h2,
      EA_PREDEC = 4'h3, EA_ABS8 = 4'h4, EA_ABS16 = 4'h5,
      EA_IMM = 4'h6, EA_PC_REL = 4'h7, EA_MEM_IND = 4'h8,
      EA_PUSH = 4'h9, EA_POP = 4'hA
   } ea_mode_type;

   typedef enum logic [3:0] {
      FC_NONE = 4'h0, FC_ARITH = 4'h1, FC_LOGIC = 4'h2,
      FC_SHIFT = 4'h3, FC_BIT_LD = 4'h4, FC_BIT_AND = 4'h5,
      FC_BIT_OR = 4'h6, FC_BIT_XOR = 4'h7, FC_LOAD = 4'h8,
      FC_AND = 4'h9, FC_OR = 4'hA, FC_XOR = 4'hB, FC_POP = 4'hC
   } flag_cmd_type;

   typedef enum logic [3:0] {
      OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3,
      OP_NEG = 4'h4, OP_CMP = 4'h5, OP_DEC_ADD = 4'h6, OP_DEC_SUB = 4'h7,
      OP_ADD_SMALL = 4'h8, OP_SUB_SMALL = 4'h9
   } alu_op_type;

   typedef enum logic [1:0] {
      AG_IDLE = 2'b01, AG_CALC = 2'b10
   } ag_state_type;
endpackage

/* File: common/gpr_bus_if.sv */
// Port bundle between the CPU register top and its register bank.
// Assumes the bank answers reads one clock after the select.
`timescale 1ns/1ns
interface gpr_bus_if;
   logic we;
   logic [2:0] wsel;
   logic [1:0] wbe;
   logic [15:0] wdata;
   logic [2:0] rsel_a;
   logic [15:0] rdata_a;
   logic [2:0] rsel_b;
   logic [15:0] rdata_b;
   modport bank (input we, wsel, wbe, wdata, rsel_a, rsel_b,
      output rdata_a, rdata_b);
   modport user (output we, wsel, wbe, wdata, rsel_a, rsel_b,
      input rdata_a, rdata_b);
endinterface

/* File: logic/gpr_bank.sv */
// Eight 16-bit general registers, byte-lane writes, two read ports.
// Assumes the caller holds clk_en for the whole access; no reset.
`timescale 1ns/1ns
module gpr_bank
   import cpu_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic clk_en,
   gpr_bus_if.bank bus
);
   logic [15:0] rdata_a_ff;
   logic [15:0] rdata_b_ff;

   // Own byte array per lane; one lane never touches the other
   for (genvar lane = 0; lane < 2; lane++) begin : g_lane
      logic [7:0] half_mem [GPR_COUNT];
      always_ff @(posedge mclk) begin
         if (clk_en && bus.we && bus.wbe[lane]) begin
            half_mem[bus.wsel] <= bus.wdata[lane*8 +: 8];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (clk_en) begin
         rdata_a_ff <= {g_lane[1].half_mem[bus.rsel_a],
            g_lane[0].half_mem[bus.rsel_a]};
         rdata_b_ff <= {g_lane[1].half_mem[bus.rsel_b],
            g_lane[0].half_mem[bus.rsel_b]};
      end
   end

   assign bus.rdata_a = rdata_a_ff;
   assign bus.rdata_b = rdata_b_ff;
endmodule

/* File: logic/cpu_regs_top.sv */
// CPU register model: general registers, program counter, flags,
// interrupt gate and effective address generation.
// Assumes inputs synchronous to mclk; memory cycles are done outside.
`timescale 1ns/1ns
module cpu_regs_top
   import cpu_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [15:0] reset_vector,
   input wire logic wr_en,
   input wire half_sel_type wr_half,
   input wire logic [2:0] wr_sel,
   input wire logic [15:0] wr_data,
   input wire logic [2:0] rd_sel,
   output logic [15:0] rd_data,
   input wire logic pc_load,
   input wire logic [15:0] pc_next,
   output logic [15:0] program_counter_ff,
   input wire flag_cmd_type flag_cmd,
   input wire alu_op_type alu_op,
   input wire logic alu_word,
   input wire logic [15:0] alu_a,
   input wire logic [15:0] alu_b,
   input wire logic shift_out,
   input wire logic bit_inv,
   output logic [7:0] condition_flags_ff,
   output logic [15:0] flags_push_ff,
   output logic [15:0] alu_result_ff,
   input wire logic irq_req,
   input wire logic nmi_req,
   output logic irq_accept_ff,
   input wire logic ag_start,
   input wire ea_mode_type ag_mode,
   input wire logic [2:0] ag_sel,
   input wire logic ag_word,
   input wire logic [15:0] ag_ext,
   output logic ag_busy_ff,
   output logic ea_valid_ff,
   output logic [15:0] ea_addr_ff
);
   function automatic logic [15:0] even(input logic [15:0] a);
      even = a & EVEN_MASK;
   endfunction

   function automatic logic [15:0] lanes(input half_sel_type h,
      input logic [15:0] d);
      lanes = (h == HALF_WORD) ? d : {d[7:0], d[7:0]};
   endfunction

   logic [1:0] rst_sync_ff;
   logic rst_int_n;
   logic vec_pending_ff;
   ag_state_type ag_state_ff, nxt_ag_state;
   ea_mode_type mode_ff;
   logic [2:0] sel_ff;
   logic word_ff;
   logic [15:0] ext_ff;
   logic [7:0] nxt_flags;
   logic [15:0] nxt_result;
   gpr_bus_if gbus ();

   gpr_bank i_gpr_bank (
      .mclk(mclk),
      .clk_en(clk_en),
      .bus(gbus)
   );

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_ff[1];

   // Address generator decode
   wire calc = (ag_state_ff == AG_CALC);
   wire stack_mode = (mode_ff == EA_PUSH) || (mode_ff == EA_POP);
   wire word_eff = word_ff || stack_mode || (mode_ff == EA_PC_REL)
      || (mode_ff == EA_MEM_IND);
   wire [15:0] step = word_eff ? STEP_WORD : STEP_BYTE;
   wire [15:0] base = gbus.rdata_b;
   wire [15:0] pc_disp = {{8{ext_ff[BYTE_MSB]}}, ext_ff[7:0]};
   wire [15:0] ea_raw =
      (mode_ff == EA_DISP16) ? base + ext_ff :
      (mode_ff == EA_PREDEC || mode_ff == EA_PUSH) ? base - step :
      (mode_ff == EA_ABS8) ? {PAGE_HIGH, ext_ff[7:0]} :
      (mode_ff == EA_ABS16) ? ext_ff :
      (mode_ff == EA_IMM) ? (word_ff ? ext_ff :
         {PAGE_ZERO, ext_ff[7:0]}) :
      (mode_ff == EA_PC_REL) ? program_counter_ff + pc_disp :
      (mode_ff == EA_MEM_IND) ? {PAGE_ZERO, ext_ff[7:0]} :
      base;
   wire is_imm = (mode_ff == EA_IMM);
   wire [15:0] ea_out = (word_eff && !is_imm) ? even(ea_raw) : ea_raw;
   wire wb_inc = (mode_ff == EA_POSTINC) || (mode_ff == EA_POP);
   wire wb_dec = (mode_ff == EA_PREDEC) || (mode_ff == EA_PUSH);
   wire wb_en = calc && (wb_inc || wb_dec);
   wire [15:0] wb_val = wb_inc ? base + step : base - step;
   wire [2:0] ag_reg = ((ag_mode == EA_PUSH) || (ag_mode == EA_POP))
      ? SP_INDEX : ag_sel;
   wire [1:0] user_be = (wr_half == HALF_WORD) ? BE_WORD :
      (wr_half == HALF_HIGH) ? BE_HIGH : BE_LOW;

   // Bank port: writeback wins, user write refused during it
   assign gbus.we = wb_en || (wr_en && !calc);
   assign gbus.wsel = wb_en ? sel_ff : wr_sel;
   assign gbus.wbe = wb_en ? BE_WORD : user_be;
   assign gbus.wdata = wb_en ? wb_val : lanes(wr_half, wr_data);
   assign gbus.rsel_a = rd_sel;
   assign gbus.rsel_b = ag_reg;
   assign rd_data = gbus.rdata_a;
   assign nxt_ag_state = calc ? AG_IDLE : (ag_start ? AG_CALC : AG_IDLE);

   always_ff @(posedge mclk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ag_state_ff <= AG_IDLE;
         ag_busy_ff <= 1'b0;
         ea_valid_ff <= 1'b0;
         ea_addr_ff <= 16'h0000;
         mode_ff <= EA_REG_IND;
         sel_ff <= 3'h0;
         word_ff <= 1'b0;
         ext_ff <= 16'h0000;
      end else if (clk_en) begin
         ag_state_ff <= nxt_ag_state;
         ag_busy_ff <= (nxt_ag_state == AG_CALC);
         ea_valid_ff <= calc;
         if (calc) begin
            ea_addr_ff <= ea_out;
         end
         if (!calc && ag_start) begin
            mode_ff <= ag_mode;
            sel_ff <= ag_reg;
            word_ff <= ag_word;
            ext_ff <= ag_ext;
         end
      end
   end

   // Arithmetic core for flags and result
   wire sub_kind = (alu_op == OP_SUB) || (alu_op == OP_SBC)
      || (alu_op == OP_NEG) || (alu_op == OP_CMP);
   wire use_c = (alu_op == OP_ADC) || (alu_op == OP_SBC);
   wire [15:0] opa = (alu_op == OP_NEG) ? 16'h0000 : alu_a;
   wire [15:0] opb = (alu_op == OP_NEG) ? alu_a : alu_b;
   wire [15:0] opb_x = sub_kind ? ~opb : opb;
   wire cin_x = sub_kind ^ (use_c && condition_flags_ff[FLAG_C]);
   wire [16:0] sum_w = {1'b0, opa} + {1'b0, opb_x} + {16'h0000, cin_x};
   wire [8:0] sum_b = {1'b0, opa[7:0]} + {1'b0, opb_x[7:0]}
      + {8'h00, cin_x};
   wire [4:0] nib_b = {1'b0, opa[3:0]} + {1'b0, opb_x[3:0]}
      + {4'h0, cin_x};
   wire [12:0] nib_w = {1'b0, opa[11:0]} + {1'b0, opb_x[11:0]}
      + {12'h000, cin_x};
   wire [15:0] ar_res = alu_word ? sum_w[15:0] : {8'h00, sum_b[7:0]};
   wire ar_carry = sub_kind ^ (alu_word ? sum_w[16] : sum_b[8]);
   wire ar_half = sub_kind ^ (alu_word ? nib_w[12] : nib_b[4]);
   wire sa = alu_word ? opa[WORD_MSB] : opa[BYTE_MSB];
   wire sb = alu_word ? opb_x[WORD_MSB] : opb_x[BYTE_MSB];
   wire sr = alu_word ? ar_res[WORD_MSB] : ar_res[BYTE_MSB];
   wire ar_ovf = (sa == sb) && (sr != sa);

   // Decimal adjust takes half-carry and carry
   wire h_in = condition_flags_ff[FLAG_H];
   wire c_in = condition_flags_ff[FLAG_C];
   wire lo_fix = h_in || (alu_a[3:0] > BCD_DIGIT_MAX);
   wire dadd_c = c_in || (alu_a[7:0] > BCD_BYTE_MAX);
   wire [7:0] dadd_res = alu_a[7:0] + (lo_fix ? BCD_LO_FIX : 8'h00)
      + (dadd_c ? BCD_HI_FIX : 8'h00);
   wire [7:0] dsub_res = alu_a[7:0] - (h_in ? BCD_LO_FIX : 8'h00)
      - (c_in ? BCD_HI_FIX : 8'h00);
   wire is_dec = (alu_op == OP_DEC_ADD) || (alu_op == OP_DEC_SUB);
   wire [7:0] dec_res = (alu_op == OP_DEC_ADD) ? dadd_res : dsub_res;
   wire small_op = (alu_op == OP_ADD_SMALL) || (alu_op == OP_SUB_SMALL);
   wire [15:0] small_k = alu_b[1] ? STEP_WORD : STEP_BYTE;
   wire [15:0] small_res = (alu_op == OP_ADD_SMALL) ? alu_a + small_k
      : alu_a - small_k;
   wire [15:0] res_sel = small_op ? small_res :
      is_dec ? {8'h00, dec_res} : ar_res;
   wire res_neg = alu_word ? res_sel[WORD_MSB] : res_sel[BYTE_MSB];
   wire res_zero = alu_word ? (res_sel == 16'h0000)
      : (res_sel[7:0] == 8'h00);
   wire log_neg = alu_word ? alu_a[WORD_MSB] : alu_a[BYTE_MSB];
   wire log_zero = alu_word ? (alu_a == 16'h0000) : (alu_a[7:0] == 8'h00);
   wire [2:0] bit_num = alu_b[BITNUM_LSB +: 3];
   wire bit_val = alu_a[bit_num] ^ bit_inv;

   always_comb begin
      nxt_flags = condition_flags_ff;
      nxt_result = alu_result_ff;
      unique case (flag_cmd)
         FC_NONE: ;
         FC_ARITH: begin
            nxt_result = res_sel;
            if (!small_op) begin
               nxt_flags[FLAG_N] = res_neg;
               nxt_flags[FLAG_Z] = res_zero;
               nxt_flags[FLAG_V] = is_dec ? 1'b0 : ar_ovf;
               nxt_flags[FLAG_C] = (alu_op == OP_DEC_ADD) ? dadd_c :
                  (alu_op == OP_DEC_SUB) ? c_in : ar_carry;
               if (!is_dec) begin
                  nxt_flags[FLAG_H] = ar_half;
               end
            end
         end
         FC_LOGIC, FC_SHIFT: begin
            nxt_result = alu_a;
            nxt_flags[FLAG_N] = log_neg;
            nxt_flags[FLAG_Z] = log_zero;
            nxt_flags[FLAG_V] = 1'b0;
            if (flag_cmd == FC_SHIFT) begin
               nxt_flags[FLAG_C] = shift_out;
            end
         end
         FC_BIT_LD: nxt_flags[FLAG_C] = bit_val;
         FC_BIT_AND: nxt_flags[FLAG_C] = c_in & bit_val;
         FC_BIT_OR: nxt_flags[FLAG_C] = c_in | bit_val;
         FC_BIT_XOR: nxt_flags[FLAG_C] = c_in ^ bit_val;
         FC_LOAD: nxt_flags = alu_b[7:0];
         FC_AND: nxt_flags = condition_flags_ff & alu_b[7:0];
         FC_OR: nxt_flags = condition_flags_ff | alu_b[7:0];
         FC_XOR: nxt_flags = condition_flags_ff ^ alu_b[7:0];
         FC_POP: nxt_flags = alu_b[15:8];
         default: ;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         condition_flags_ff <= FLAGS_RESET;
         alu_result_ff <= 16'h0000;
         flags_push_ff <= {FLAGS_RESET, FLAGS_RESET};
         irq_accept_ff <= 1'b0;
      end else if (clk_en) begin
         condition_flags_ff <= nxt_flags;
         alu_result_ff <= nxt_result;
         flags_push_ff <= {nxt_flags, nxt_flags};
         irq_accept_ff <= nmi_req ||
            (irq_req && !condition_flags_ff[FLAG_I]);
      end
   end

   // Program counter, vector fetched once after reset release
   always_ff @(posedge mclk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         vec_pending_ff <= 1'b1;
         program_counter_ff <= 16'h0000;
      end else if (clk_en) begin
         vec_pending_ff <= 1'b0;
         if (vec_pending_ff) begin
            program_counter_ff <= even(reset_vector);
         end else if (pc_load) begin
            program_counter_ff <= even(pc_next);
         end
      end
   end

   default clocking cb @(posedge mclk iff clk_en); endclocking
   default disable iff (!rst_int_n);

   sequence s_post_byte;
      ag_start && !calc && ag_mode == EA_POSTINC && !ag_word;
   endsequence
   sequence s_pre_word;
      ag_start && !calc && ag_mode == EA_PREDEC && ag_word;
   endsequence

   a_pc_load_even: assert property (!vec_pending_ff && pc_load |=>
      program_counter_ff == even($past(pc_next)))
      else $error("pc load wrong");
   a_irq_masked: assert property (irq_req && !nmi_req &&
      condition_flags_ff[FLAG_I] |=> !irq_accept_ff)
      else $error("masked interrupt accepted");
   a_nmi_passes: assert property (nmi_req |=> irq_accept_ff)
      else $error("nmi not accepted");
   a_post_step: assert property (s_post_byte |=>
      (gbus.we && gbus.wdata == gbus.rdata_b + STEP_BYTE)
      ##1 (ea_valid_ff && ea_addr_ff == $past(gbus.rdata_b)))
      else $error("post-increment wrong");
   a_pre_step: assert property (s_pre_word |=> ##1
      (ea_valid_ff && ea_addr_ff == even($past(gbus.rdata_b) - STEP_WORD)))
      else $error("pre-decrement wrong");
   a_abs8_page: assert property (ea_valid_ff &&
      $past(mode_ff) == EA_ABS8 |-> ea_addr_ff[15:8] == PAGE_HIGH)
      else $error("short absolute page wrong");
   a_byte_half: assert property (flag_cmd == FC_ARITH &&
      alu_op == OP_ADD && !alu_word |=> condition_flags_ff[FLAG_H] ==
      ($past(alu_a[3:0]) + $past(alu_b[3:0]) > 5'h0F))
      else $error("byte half-carry wrong");
   a_zero_flag: assert property (flag_cmd == FC_ARITH &&
      alu_op == OP_ADD && alu_word |=> condition_flags_ff[FLAG_Z] ==
      ($past(alu_a) + $past(alu_b) == 16'h0000))
      else $error("zero flag wrong");
   a_flags_push: assert property (flag_cmd == FC_POP |=>
      condition_flags_ff == $past(alu_b[15:8]) &&
      flags_push_ff[15:8] == flags_push_ff[7:0])
      else $error("flag pop wrong");
   a_user_bits: assert property (flag_cmd inside {FC_ARITH, FC_LOGIC,
      FC_SHIFT} |=> $stable(condition_flags_ff[FLAG_U6]) &&
      $stable(condition_flags_ff[FLAG_U4]))
      else $error("user bits changed");
endmodule

/* File: test/mem_model.sv */
// Word-wide behavioural memory on the far side of the address path.
// Assumes the address comes from ea_addr_ff; writes land on mclk rise.
`timescale 1ns/1ns
module mem_model (
   input wire logic mclk,
   input wire logic we,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [15:0] mem [0:32767];
   // Lowest address bit ignored for words
   assign rdata = mem[addr[15:1]];
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr[15:1]] <= wdata; // Stack word kept whole
      end
   end
endmodule

/* File: test/cpu_regs_flags_and_addr_gen_bench.sv */
// Self-checking bench for the CPU register model and address generator.
// Assumes one 25 MHz clock; memory partner sits on ea_addr_ff.
`timescale 1ns/1ns
module cpu_regs_flags_and_addr_gen_bench;
   import cpu_regs_pkg::*;
   localparam logic [15:0] RVEC = 16'h0457;
   logic mclk, rst_n, wr_en, pc_load, irq_req, nmi_req, ag_start, ag_word;
   logic shift_out, bit_inv, alu_word, mem_we, clk_en;
   half_sel_type wr_half;
   logic [2:0] wr_sel, rd_sel, ag_sel;
   logic [15:0] wr_data, pc_next, alu_a, alu_b, ag_ext;
   flag_cmd_type flag_cmd;
   alu_op_type alu_op;
   ea_mode_type ag_mode;
   logic [15:0] rd_data, pc, push, res, ea, mem_rdata, d;
   logic [7:0] flags;
   logic irq_acc, busy, ev;
   int n_fail = 0;
   int checks = 0;
   logic [31:0] seed = 32'hFF3A5A3E;
   logic [15:0] q[$];
   logic [15:0] rv [0:7];

   cpu_regs_top i_cpu_regs_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
      .reset_vector(RVEC), .wr_en(wr_en), .wr_half(wr_half),
      .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel),
      .rd_data(rd_data), .pc_load(pc_load), .pc_next(pc_next),
      .program_counter_ff(pc), .flag_cmd(flag_cmd), .alu_op(alu_op),
      .alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b),
      .shift_out(shift_out), .bit_inv(bit_inv),
      .condition_flags_ff(flags), .flags_push_ff(push),
      .alu_result_ff(res), .irq_req(irq_req), .nmi_req(nmi_req),
      .irq_accept_ff(irq_acc), .ag_start(ag_start), .ag_mode(ag_mode),
      .ag_sel(ag_sel), .ag_word(ag_word), .ag_ext(ag_ext),
      .ag_busy_ff(busy), .ea_valid_ff(ev), .ea_addr_ff(ea));
   mem_model i_mem_model (.mclk(mclk), .we(mem_we), .addr(ea),
      .wdata(push), .rdata(mem_rdata));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wreg(logic [2:0] s, half_sel_type h, logic [15:0] v);
      @(posedge mclk);
      wr_en <= 1'b1;
      wr_sel <= s;
      wr_half <= h;
      wr_data <= v;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   task automatic creg(logic [2:0] s, logic [15:0] e);
      @(posedge mclk);
      rd_sel <= s;
      @(posedge mclk);
      @(negedge mclk);
      chk("gpr", rd_data, e);
   endtask

   task automatic fop(flag_cmd_type c, alu_op_type o, logic w,
      logic [15:0] a, logic [15:0] b, logic [1:0] sb);
      @(posedge mclk);
      flag_cmd <= c;
      alu_op <= o;
      alu_word <= w;
      alu_a <= a;
      alu_b <= b;
      {shift_out, bit_inv} <= sb;
      @(posedge mclk);
      flag_cmd <= FC_NONE;
      @(negedge mclk);
   endtask

   task automatic fchk(flag_cmd_type c, logic [15:0] b, logic [7:0] f);
      fop(c, OP_ADD, 1'b0, 16'h0000, b, 2'h0);
      chk("flags", 16'(flags), 16'(f));
   endtask

   task automatic ar(alu_op_type o, logic w, logic [15:0] a,
      logic [15:0] b, logic [15:0] r, logic [7:0] f);
      fop(FC_ARITH, o, w, a, b, 2'h0);
      chk("result", res, r);
      chk("flags", 16'(flags), 16'(f));
   endtask

   task automatic ag(ea_mode_type m, logic [2:0] s, logic w,
      logic [15:0] x, logic [15:0] e);
      q.push_back(e);
      @(posedge mclk);
      ag_start <= 1'b1;
      ag_mode <= m;
      ag_sel <= s;
      ag_word <= w;
      ag_ext <= x;
      @(posedge mclk);
      ag_start <= 1'b0;
      @(negedge mclk);
      chk("ag_busy", 16'(busy), 16'h0001);
      repeat (2) @(posedge mclk);
   endtask

   task automatic pin(logic i, logic n, logic e);
      @(posedge mclk);
      irq_req <= i;
      nmi_req <= n;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("irq_accept", 16'(irq_acc), 16'(e));
   endtask

   always @(negedge mclk) begin
      if (ev === 1'b1) begin
         if (q.size() == 0) begin
            chk("ea_extra", 16'h0001, 16'h0000);
         end else begin
            chk("ea_addr", ea, q.pop_front());
         end
      end
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      end_sim();
   end

   initial begin
      {rst_n, wr_en, pc_load, irq_req, nmi_req, ag_start, ag_word} = 7'h00;
      {shift_out, bit_inv, alu_word, mem_we} = 4'h0;
      clk_en = 1'b1;
      {wr_sel, rd_sel, ag_sel} = 9'h000;
      {wr_data, pc_next, alu_a, alu_b, ag_ext} = 80'h0;
      wr_half = HALF_WORD;
      flag_cmd = FC_NONE;
      alu_op = OP_ADD;
      ag_mode = EA_REG_IND;
      repeat (2) @(negedge mclk);
      chk("flags_rst", 16'(flags), 16'h0080);
      chk("push_rst", push, 16'h8080);
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (5) @(negedge mclk);
      chk("pc_rst", pc, RVEC & EVEN_MASK);
      pin(1'b1, 1'b0, 1'b0);
      fchk(FC_LOAD, 16'h0050, 8'h50);
      @(negedge mclk);
      chk("irq_open", 16'(irq_acc), 16'h0001);
      fchk(FC_AND, 16'h0010, 8'h10);
      fchk(FC_OR, 16'h0040, 8'h50);
      fchk(FC_XOR, 16'h0090, 8'hC0);
      pin(1'b1, 1'b0, 1'b0);
      pin(1'b1, 1'b1, 1'b1);
      pin(1'b0, 1'b0, 1'b0);
      ar(OP_ADD, 1'b0, 16'h000F, 16'h0001, 16'h0010, 8'hE0);
      ar(OP_ADD, 1'b0, 16'h007F, 16'h0001, 16'h0080, 8'hEA);
      ar(OP_ADD, 1'b0, 16'h00FF, 16'h0001, 16'h0000, 8'hE5);
      ar(OP_SUB, 1'b0, 16'h0010, 16'h0001, 16'h000F, 8'hE0);
      ar(OP_CMP, 1'b0, 16'h0005, 16'h0005, 16'h0000, 8'hC4);
      ar(OP_ADD, 1'b1, 16'h0FFF, 16'h0001, 16'h1000, 8'hE0);
      ar(OP_ADD, 1'b1, 16'h7FFF, 16'h0001, 16'h8000, 8'hEA);
      ar(OP_ADD_SMALL, 1'b1, 16'h1234, 16'h0002, 16'h1236, 8'hEA);
      ar(OP_SUB_SMALL, 1'b1, 16'h1234, 16'h0000, 16'h1233, 8'hEA);
      fop(FC_SHIFT, OP_ADD, 1'b0, 16'h0000, 16'h0000, 2'h2);
      chk("carry_shift", 16'(flags[FLAG_C]), 16'h0001);
      fop(FC_BIT_LD, OP_ADD, 1'b0, 16'h0020, 16'h0050, 2'h0);
      chk("carry_bit", 16'(flags[FLAG_C]), 16'h0001);
      fop(FC_BIT_LD, OP_ADD, 1'b0, 16'h0020, 16'h0050, 2'h1);
      chk("carry_inv", 16'(flags[FLAG_C]), 16'h0000);
      @(posedge mclk);
      clk_en <= 1'b0;
      fop(FC_LOAD, OP_ADD, 1'b0, 16'h0000, 16'h0011, 2'h0);
      chk("frozen", 16'(flags), 16'h00E4);
      @(posedge mclk);
      clk_en <= 1'b1;
      @(posedge mclk);
      pc_load <= 1'b1;
      pc_next <= 16'h1235;
      @(posedge mclk);
      pc_load <= 1'b0;
      @(negedge mclk);
      chk("pc", pc, 16'h1234);
      for (int i = 0; i < 8; i++) begin
         rv[i] = 16'(rnd());
         wreg(3'(i), HALF_WORD, rv[i]);
      end
      for (int i = 0; i < 8; i++) begin
         creg(3'(i), rv[i]);
      end
      wreg(3'h2, HALF_HIGH, 16'h00A5);
      creg(3'h2, {8'hA5, rv[2][7:0]});
      wreg(3'h2, HALF_LOW, 16'h005A);
      creg(3'h2, 16'hA55A);
      d = 16'(rnd());
      ag(EA_DISP16, 3'h1, 1'b0, d, rv[1] + d);
      ag(EA_DISP16, 3'h1, 1'b1, d, (rv[1] + d) & EVEN_MASK);
      wreg(3'h3, HALF_WORD, 16'h2000);
      ag(EA_POSTINC, 3'h3, 1'b1, 16'h0000, 16'h2000);
      creg(3'h3, 16'h2002);
      ag(EA_POSTINC, 3'h3, 1'b0, 16'h0000, 16'h2002);
      creg(3'h3, 16'h2003);
      ag(EA_PREDEC, 3'h3, 1'b0, 16'h0000, 16'h2002);
      creg(3'h3, 16'h2002);
      ag(EA_PREDEC, 3'h3, 1'b1, 16'h0000, 16'h2000);
      creg(3'h3, 16'h2000);
      ag(EA_ABS8, 3'h0, 1'b0, 16'h0042, 16'hFF42);
      ag(EA_ABS16, 3'h0, 1'b0, 16'h3457, 16'h3457);
      ag(EA_ABS16, 3'h0, 1'b1, 16'h3457, 16'h3456);
      ag(EA_IMM, 3'h0, 1'b1, d, d);
      ag(EA_PC_REL, 3'h0, 1'b0, 16'h0080, 16'h11B4);
      ag(EA_PC_REL, 3'h0, 1'b0, 16'h007F, 16'h12B2);
      ag(EA_MEM_IND, 3'h0, 1'b1, 16'hAB33, 16'h0032);
      wreg(3'h7, HALF_WORD, 16'h0200);
      ag(EA_PUSH, 3'h0, 1'b0, 16'h0000, 16'h01FE);
      mem_we <= 1'b1;
      @(posedge mclk);
      mem_we <= 1'b0;
      creg(3'h7, 16'h01FE);
      chk("stack_word", mem_rdata, 16'hE4E4);
      fchk(FC_LOAD, 16'h0000, 8'h00);
      ag(EA_POP, 3'h0, 1'b0, 16'h0000, 16'h01FE);
      fop(FC_POP, OP_ADD, 1'b0, 16'h0000,
         {mem_rdata[15:8], ~mem_rdata[7:0]}, 2'h0);
      chk("flags_pop", push, 16'hE4E4);
      creg(3'h7, 16'h0200);
      chk("ea_left", 16'(q.size()), 16'h0000);
      end_sim();
   end
endmodule
